// ===== core/sgdpm_pkg.sv
// Purpose: shared constants and carriers of the descriptor prefetch manager
// Assumes: one 10 MHz clock, Avalon-MM register slave, 32-bit data
// Notes:   offsets are byte addresses of aligned words
package sgdpm_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_ADDR_LOW = 5'h00; // first descriptor, low
    localparam logic [4:0] OFS_ADDR_HIGH = 5'h04; // first descriptor, high
    localparam logic [4:0] OFS_CONTROL = 5'h08; // run level and sizes
    localparam logic [4:0] OFS_TIMEOUT = 5'h0c; // completion timeout
    localparam logic [4:0] OFS_STATUS = 5'h10; // loader state, cache level

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int RUN_LSB = 0;  // run level 3..0
    localparam int CUR_LSB = 24; // current group size code 27..24
    localparam int MAX_LSB = 28; // largest group size code 31..28
    localparam int TMO_DIS_BIT = 31; // completion timeout switched off
    localparam int ST_LVL_LSB = 8;  // status: cache level 23..8
    localparam int ST_TMO_BIT = 30; // status: timeout seen, sticky
    localparam int ST_FULL_BIT = 31; // status: cache full

    // ------------------------------------------------------------------
    // run level codes and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] RUN_IDLE = 4'h0;
    localparam logic [3:0] RUN_GO = 4'h1;
    localparam logic [3:0] RUN_ABORT = 4'h2;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_TMO = 16'hffff; // longest wait by default

    // ------------------------------------------------------------------
    // timing: completion timeout unit and clock period
    // ------------------------------------------------------------------
    localparam int TMO_UNIT_NS = 4;
    localparam int CLK_PERIOD_NS = 100;
    localparam logic [19:0] STEP_NS = 20'(CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // group sizing: read request size code n means 128 << n bytes
    // ------------------------------------------------------------------
    localparam int MRRS_BASE_LOG2 = 7;
    localparam int DESC_BYTES_LOG2 = 4; // one descriptor is 16 bytes
    localparam logic [3:0] GROUP_CODE_MAX = 4'hf; // 32K descriptors
    localparam int DESC_W = 128;

    // loader states
    typedef enum logic [1:0] {LD_IDLE, LD_ISSUE, LD_WAIT} sgdpm_state_t;

    // grouped memory read request towards the host link
    typedef struct packed {
        logic        valid; // request pending
        logic [63:0] addr;  // host byte address of the group
        logic [3:0]  code;  // group size, 1 << code descriptors
    } sgdpm_rdreq_t;

    // one descriptor returned by the host link, in request order
    typedef struct packed {
        logic              valid; // beat present
        logic [DESC_W-1:0] data;  // descriptor contents
    } sgdpm_cpl_t;

    // descriptor handed to the acquisition engine
    typedef struct packed {
        logic              valid; // a cached descriptor is offered
        logic [DESC_W-1:0] data;  // oldest cached descriptor
    } sgdpm_desc_t;

endpackage : sgdpm_pkg

// ===== core/sgdpm_top.sv
// Purpose: descriptor prefetch and cache for a scatter-gather DMA
// Assumes: host link returns a group in order, one a beat
// Notes:   one clock; registers over Avalon-MM with waitrequest
// How it works
// - each descriptor moves one contiguous chunk
// - prefetch into cache, hand out in order
// - loader independent, throttled by run level
// - loading continues whatever the acquisition state
// - full cache suspends fetches, keeps state
// - abort flushes cache and prefetch pipeline
// - first descriptor address low word
// - first descriptor address high word
// - run level idle, run, abort
// - current group size, power-of-two code
// - one large read per group
// - largest group derived from read request size
// - completion timeout in 4 ns units
// - timeout fields writable only while idle
// - bit 31 switches completion timeout off
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
module sgdpm_top #(
    parameter int CACHE_AW = 4 // cache holds 1 << CACHE_AW descriptors
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    // avalon-mm register slave
    input  wire logic [4:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    // link configuration from enumeration
    input  wire logic [2:0]             max_read_req_code,
    // grouped read requests and their completions
    output sgdpm_pkg::sgdpm_rdreq_t     rd_req,
    input  wire logic                   rd_req_ready,
    input  wire sgdpm_pkg::sgdpm_cpl_t  cpl,
    // descriptors towards the acquisition engine
    output sgdpm_pkg::sgdpm_desc_t      desc_out,
    input  wire logic                   desc_ready
);

    localparam int DEPTH = 1 << CACHE_AW;
    localparam int DESC_W_L = sgdpm_pkg::DESC_W;

    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    logic [31:0]            first_descriptor_addr_low_r;  // software pointer
    logic [31:0]            first_descriptor_addr_high_r; // software pointer
    logic [3:0]             loader_run_level_r; // run control field
    logic [15:0]            tmo_limit_r;        // wait limit, 4 ns units
    logic                   tmo_disable_r;      // wait forever when set
    logic                   tmo_seen_r;         // sticky timeout flag
    sgdpm_pkg::sgdpm_state_t loader_state;      // loader sequencer
    logic [63:0]            fetch_addr_r;       // next group address
    logic                   reload_r;           // take first pointer on run
    logic [15:0]            beats_left_r;       // descriptors still due
    logic [19:0]            wait_ns_r;          // time since last beat
    logic                   ack_r;              // bus answer cycle
    logic [31:0]            rdata_r;            // captured read word
    logic [DESC_W_L-1:0]    cache_mem [DEPTH];  // descriptor storage
    logic [CACHE_AW-1:0]    wr_ptr_r;           // next free entry
    logic [CACHE_AW-1:0]    rd_ptr_r;           // oldest entry
    logic [CACHE_AW:0]      level_r;            // entries held

    // ------------------------------------------------------------------
    // derived group sizes
    // ------------------------------------------------------------------
    logic [3:0]  max_code;   // largest group allowed by the link
    logic [3:0]  cur_code;   // group size actually fetched
    logic [16:0] group_cnt;  // descriptors in one group
    logic [16:0] free_cnt;   // empty cache entries
    logic        full;       // cache holds DEPTH entries
    logic        empty;      // cache holds nothing

    // request bytes over descriptor bytes, as a log2
    always_comb begin
        max_code = 4'(int'(max_read_req_code) + sgdpm_pkg::MRRS_BASE_LOG2
                      - sgdpm_pkg::DESC_BYTES_LOG2);
        if (max_code > sgdpm_pkg::GROUP_CODE_MAX) begin
            max_code = sgdpm_pkg::GROUP_CODE_MAX;
        end
        // a group never exceeds what the cache can take in one go
        cur_code = (max_code > 4'(CACHE_AW)) ? 4'(CACHE_AW) : max_code;
    end

    assign group_cnt = 17'h1 << cur_code;
    assign free_cnt  = 17'(DEPTH) - 17'(level_r);
    assign full      = (level_r == (CACHE_AW + 1)'(DEPTH));
    assign empty     = (level_r == '0);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic        bus_req;    // a request is on the bus
    logic        wr_take;    // write takes effect this edge
    logic [31:0] ctrl_word;  // control register as read
    logic [31:0] tmo_word;   // timeout register as read
    logic [31:0] stat_word;  // status register as read
    logic        run_wr;     // write to the control register
    logic [3:0]  run_val;    // run level written
    logic        abort_cmd;  // abort requested this edge
    logic        start_cmd;  // run requested this edge

    assign bus_req = avs_read | avs_write;
    // one wait cycle, then the answer; keeps read data a flop output
    assign avs_waitrequest = bus_req & ~ack_r;
    assign wr_take = avs_write & ack_r;
    assign avs_readdata = rdata_r;

    // merge enabled byte lanes of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  be);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // readback words
    always_comb begin
        ctrl_word = '0;
        ctrl_word[sgdpm_pkg::RUN_LSB +: 4] = loader_run_level_r;
        ctrl_word[sgdpm_pkg::CUR_LSB +: 4] = cur_code;
        ctrl_word[sgdpm_pkg::MAX_LSB +: 4] = max_code;
        tmo_word = '0;
        tmo_word[15:0] = tmo_limit_r;
        tmo_word[sgdpm_pkg::TMO_DIS_BIT] = tmo_disable_r;
        stat_word = '0;
        stat_word[1:0] = loader_state;
        stat_word[sgdpm_pkg::ST_LVL_LSB +: CACHE_AW + 1] = level_r;
        stat_word[sgdpm_pkg::ST_TMO_BIT] = tmo_seen_r;
        stat_word[sgdpm_pkg::ST_FULL_BIT] = full;
    end

    // run level writes; byte 0 holds the whole field
    always_comb begin
        run_wr    = wr_take && (avs_address == sgdpm_pkg::OFS_CONTROL)
                    && avs_byteenable[0];
        run_val   = avs_writedata[sgdpm_pkg::RUN_LSB +: 4];
        abort_cmd = run_wr && (run_val == sgdpm_pkg::RUN_ABORT);
        start_cmd = run_wr && (run_val == sgdpm_pkg::RUN_GO);
    end

    // ------------------------------------------------------------------
    // bus answer and read capture
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ack_r   <= 1'b0;
            rdata_r <= sgdpm_pkg::RST_WORD;
        end else begin
            ack_r <= bus_req & ~ack_r;
            if (avs_read && !ack_r) begin
                case (avs_address)
                    sgdpm_pkg::OFS_ADDR_LOW:  rdata_r <= first_descriptor_addr_low_r;
                    sgdpm_pkg::OFS_ADDR_HIGH: rdata_r <= first_descriptor_addr_high_r;
                    sgdpm_pkg::OFS_CONTROL:   rdata_r <= ctrl_word;
                    sgdpm_pkg::OFS_TIMEOUT:   rdata_r <= tmo_word;
                    sgdpm_pkg::OFS_STATUS:    rdata_r <= stat_word;
                    default:                  rdata_r <= '0; // unmapped
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // first descriptor pointer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            first_descriptor_addr_low_r  <= sgdpm_pkg::RST_WORD;
            first_descriptor_addr_high_r <= sgdpm_pkg::RST_WORD;
        end else if (wr_take) begin
            if (avs_address == sgdpm_pkg::OFS_ADDR_LOW) begin
                first_descriptor_addr_low_r <= merge(
                    first_descriptor_addr_low_r, avs_writedata,
                    avs_byteenable);
            end
            if (avs_address == sgdpm_pkg::OFS_ADDR_HIGH) begin
                first_descriptor_addr_high_r <= merge(
                    first_descriptor_addr_high_r, avs_writedata,
                    avs_byteenable);
            end
        end
    end

    // ------------------------------------------------------------------
    // run level: abort falls back to idle once taken
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            loader_run_level_r <= sgdpm_pkg::RUN_IDLE;
        end else if (run_wr) begin
            case (run_val)
                sgdpm_pkg::RUN_IDLE:  loader_run_level_r <= run_val;
                sgdpm_pkg::RUN_GO:    loader_run_level_r <= run_val;
                sgdpm_pkg::RUN_ABORT: loader_run_level_r <= run_val;
                default: ; // reserved codes change nothing
            endcase
        end else if (loader_run_level_r == sgdpm_pkg::RUN_ABORT) begin
            loader_run_level_r <= sgdpm_pkg::RUN_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // timeout register, locked unless the loader is idle
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tmo_limit_r   <= sgdpm_pkg::RST_TMO;
            tmo_disable_r <= 1'b0;
        end else if (wr_take && avs_address == sgdpm_pkg::OFS_TIMEOUT
                     && loader_state == sgdpm_pkg::LD_IDLE) begin
            if (avs_byteenable[0]) begin
                tmo_limit_r[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                tmo_limit_r[15:8] <= avs_writedata[15:8];
            end
            if (avs_byteenable[3]) begin
                tmo_disable_r <= avs_writedata[sgdpm_pkg::TMO_DIS_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // loader sequencer
    // ------------------------------------------------------------------
    logic [19:0] limit_ns;  // wait limit in nanoseconds
    logic        tmo_hit;   // completion took too long
    logic        beat;      // a descriptor arrives

    assign limit_ns = 20'(tmo_limit_r) * 20'(sgdpm_pkg::TMO_UNIT_NS);
    // longest wait rounds down: fire once the next step would pass it
    assign tmo_hit  = !tmo_disable_r && !beat
                      && (wait_ns_r + sgdpm_pkg::STEP_NS > limit_ns);
    assign beat     = cpl.valid && (loader_state == sgdpm_pkg::LD_WAIT);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            loader_state <= sgdpm_pkg::LD_IDLE;
            fetch_addr_r <= '0;
            reload_r     <= 1'b1;
            beats_left_r <= '0;
            wait_ns_r    <= '0;
        end else if (abort_cmd) begin
            // pipeline dropped; next run restarts at the first pointer
            loader_state <= sgdpm_pkg::LD_IDLE;
            reload_r     <= 1'b1;
            beats_left_r <= '0;
        end else begin
            case (loader_state)
                sgdpm_pkg::LD_IDLE: begin
                    // keeps loading whatever the consumer is doing
                    if (loader_run_level_r == sgdpm_pkg::RUN_GO) begin
                        if (reload_r) begin
                            fetch_addr_r <= {first_descriptor_addr_high_r,
                                             first_descriptor_addr_low_r};
                            reload_r <= 1'b0;
                        end
                        loader_state <= sgdpm_pkg::LD_ISSUE;
                    end
                end
                sgdpm_pkg::LD_ISSUE: begin
                    if (loader_run_level_r != sgdpm_pkg::RUN_GO) begin
                        loader_state <= sgdpm_pkg::LD_IDLE;
                    end else if (rd_req_ready && free_cnt >= group_cnt) begin
                        // whole group in one request
                        beats_left_r <= 16'(group_cnt);
                        wait_ns_r    <= '0;
                        loader_state <= sgdpm_pkg::LD_WAIT;
                    end
                    // too little room: wait here, address kept
                end
                sgdpm_pkg::LD_WAIT: begin
                    if (beat) begin
                        wait_ns_r <= '0;
                        beats_left_r <= beats_left_r - 16'h1;
                        if (beats_left_r == 16'h1) begin
                            fetch_addr_r <= fetch_addr_r + 64'(
                                {group_cnt, 4'h0});
                            loader_state <= sgdpm_pkg::LD_ISSUE;
                        end
                    end else if (tmo_hit) begin
                        // give up on the group; restarts at the first pointer while run level stays run
                        loader_state <= sgdpm_pkg::LD_IDLE;
                        reload_r     <= 1'b1;
                    end else begin
                        wait_ns_r <= wait_ns_r + sgdpm_pkg::STEP_NS;
                    end
                end
                default: loader_state <= sgdpm_pkg::LD_IDLE;
            endcase
        end
    end

    // sticky timeout flag; a new run clears it unless a hit lands too
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tmo_seen_r <= 1'b0;
        end else if (loader_state == sgdpm_pkg::LD_WAIT && tmo_hit
                     && !abort_cmd) begin
            tmo_seen_r <= 1'b1; // set wins over clear
        end else if (start_cmd) begin
            tmo_seen_r <= 1'b0;
        end
    end

    // request drives straight from the sequencer state
    always_comb begin
        rd_req.valid = (loader_state == sgdpm_pkg::LD_ISSUE)
                       && (loader_run_level_r == sgdpm_pkg::RUN_GO)
                       && (free_cnt >= group_cnt);
        rd_req.addr  = fetch_addr_r;
        rd_req.code  = cur_code;
    end

    // ------------------------------------------------------------------
    // descriptor cache, in order
    // ------------------------------------------------------------------
    logic push; // descriptor written into cache
    logic pop;  // descriptor taken by acquisition

    assign push = beat && !abort_cmd;
    // nothing offered while empty; the consumer simply waits
    assign pop  = desc_ready && !empty && !abort_cmd;

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge ref_clk) begin
            if (push && wr_ptr_r == CACHE_AW'(i)) begin
                cache_mem[i] <= cpl.data;
            end
        end
    end

    // pointers and level; abort empties everything at once
    always_ff @(posedge ref_clk) begin
        if (sys_rst || abort_cmd) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            level_r <= level_r + (CACHE_AW + 1)'(push)
                               - (CACHE_AW + 1)'(pop);
        end
    end

    // oldest entry shown; storage is flops, data muxed out by rd_ptr_r
    always_comb begin
        desc_out.valid = !empty;
        desc_out.data  = cache_mem[rd_ptr_r];
    end

endmodule : sgdpm_top

// ===== testbench/sgdpm_assertions.sv
// Purpose: port checks of the prefetch manager
// Assumes: one clock, synchronous reset
// Notes:   bound at the foot
module sgdpm_assertions #(
    parameter int CACHE_AW = 4 // cache depth, log2
) (
    // clock and reset
    input wire logic                    ref_clk,
    input wire logic                    sys_rst,
    // register bus
    input wire logic [4:0]              avs_address,
    input wire logic                    avs_read,
    input wire logic                    avs_write,
    input wire logic [31:0]             avs_readdata,
    input wire logic                    avs_waitrequest,
    // link and engine sides
    input wire logic [2:0]              max_read_req_code,
    input wire sgdpm_pkg::sgdpm_rdreq_t rd_req,
    input wire logic                    rd_req_ready,
    input wire sgdpm_pkg::sgdpm_desc_t  desc_out,
    input wire logic                    desc_ready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [3:0] code_exp; // due group code
    assign code_exp = (4'(max_read_req_code) + 4'h3 > 4'(CACHE_AW)) ?
        4'(CACHE_AW) : 4'(max_read_req_code) + 4'h3;
    // one wait, then the answer
    sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_ack; (avs_read || avs_write) && !avs_waitrequest; endsequence
    AST_WAIT_ONE: assert property (s_req |=> s_ack)
        else $error("no answer after one wait");
    AST_RST_EMPTY: assert property ($past(sys_rst) |->
        !rd_req.valid && !desc_out.valid) else $error("not empty after reset");
    AST_ONE_GROUP: assert property (rd_req.valid && rd_req_ready
        |=> !rd_req.valid) else $error("group while one owed");
    AST_GROUP_CODE: assert property (rd_req.valid
        |-> rd_req.code == code_exp) else $error("wrong group size");
    AST_REQ_HOLD: assert property (rd_req.valid && !rd_req_ready
        |=> !rd_req.valid || $stable(rd_req.addr)) else $error("addr moved");
    AST_HEAD_HOLD: assert property (desc_out.valid && !desc_ready
        |=> !desc_out.valid || $stable(desc_out.data)) else $error("head moved");
    AST_UNMAPPED: assert property (s_ack ##0 avs_read &&
        avs_address > 5'h10 |-> avs_readdata == 32'h0) else $error("unmapped");
    AST_CTRL_RO: assert property (s_ack ##0 avs_read && avs_address ==
        sgdpm_pkg::OFS_CONTROL |-> avs_readdata[27:24] == code_exp &&
        avs_readdata[23:4] == 20'h0) else $error("control fields");
endmodule : sgdpm_assertions
bind sgdpm_top sgdpm_assertions #(.CACHE_AW(CACHE_AW)) chk_u (
    .ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .max_read_req_code, .rd_req, .rd_req_ready, .desc_out,
    .desc_ready);

// ===== testbench/sgdpm_host_model.sv
// Purpose: host memory answering grouped descriptor reads
// Assumes: the descriptor at byte address a holds {a, a}
// Notes:   slow halves the grant and beat rate
module sgdpm_host_model (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // pacing
    input  wire logic                    slow,
    // link towards the device
    input  wire sgdpm_pkg::sgdpm_rdreq_t rd_req,
    output logic                         rd_req_ready,
    output sgdpm_pkg::sgdpm_cpl_t        cpl
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [63:0] addr_r; // next beat address, 16 bytes on within the group
    int          left_r; // beats still owed
    logic        tick_r = 1'b0; // pacing phase
    // one group at a time; no grant while beats are owed
    always @(posedge ref_clk) begin
        tick_r <= !tick_r || !slow;
        cpl.valid <= 1'b0;
        cpl.data <= ~cpl.data; // idle line never repeats a beat
        if (sys_rst) begin
            cpl <= '0;
            left_r <= 0;
            rd_req_ready <= 1'b0;
        end else if (left_r != 0) begin
            rd_req_ready <= 1'b0;
            if (tick_r) begin
                cpl <= {1'b1, addr_r, addr_r};
                addr_r <= addr_r + 64'h10;
                left_r <= left_r - 1;
            end
        end else if (rd_req.valid && rd_req_ready) begin
            addr_r <= rd_req.addr;
            left_r <= 1 << rd_req.code;
            rd_req_ready <= 1'b0;
        end else
            rd_req_ready <= tick_r;
    end
endmodule : sgdpm_host_model

// ===== testbench/tb.sv
// Purpose: self-checking bench of the prefetch manager
// Assumes: cache of 16, groups of 8 then 16 descriptors
// Notes:   driver queues notes; monitor checks pops
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, slow = 1'b1;
    logic        avs_read = 1'b0, avs_write = 1'b0, desc_ready = 1'b0;
    logic        rd_req_ready, avs_waitrequest;
    logic [4:0]  avs_address = 5'h00;
    logic [2:0]  mrr = 3'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q, seed = 32'haf06;
    logic [63:0] first;
    logic [127:0] exp_q[$];
    int          failures = 0, tests_run = 0, pops = 0, lim = 0, cyc = 0;
    sgdpm_pkg::sgdpm_rdreq_t rd_req;
    sgdpm_pkg::sgdpm_cpl_t   cpl;
    sgdpm_pkg::sgdpm_desc_t  desc_out;
    always #50 ref_clk = ~ref_clk;
    sgdpm_top #(.CACHE_AW(4)) dut_u (.ref_clk, .sys_rst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
        .avs_readdata, .avs_waitrequest, .max_read_req_code(mrr), .rd_req,
        .rd_req_ready, .cpl, .desc_out, .desc_ready);
    sgdpm_host_model host_u (.ref_clk, .sys_rst, .slow, .rd_req,
        .rd_req_ready, .cpl);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [127:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    // held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(string n, logic [4:0] a, logic [31:0] m, e);
        bus(1'b0, a, 32'h0);
        chk(n, q & m, e);
    endtask : rd
    task automatic due(input int n); // queue n notes
        for (int k = 0; k < n; k++) exp_q.push_back({2{first + 64'(k * 16)}});
        lim = pops + n;
    endtask : due
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    // engine side: random stalls, oldest note checked
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            finish_test();
        end
        if (!sys_rst && desc_out.valid === 1'b1 && desc_ready === 1'b1) begin
            pops++;
            chk("queue", 128'(exp_q.size() != 0), 128'h1);
            chk("descriptor", desc_out.data, exp_q.pop_front());
        end
        desc_ready <= seed[0] && pops < lim;
        seed <= lfsr(seed);
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd("ctl rst", 5'h08, 32'h0fff_ffff, 32'h0300_0000);
        rd("tmo rst", 5'h0c, 32'hffff_ffff, 32'h0000_ffff);
        first = {32'h0000_0001, lfsr(seed) & 32'hffff_fff0};
        bus(1'b1, 5'h00, first[31:0]);
        bus(1'b1, 5'h04, first[63:32]);
        rd("addr lo", 5'h00, 32'hffff_ffff, first[31:0]);
        rd("addr hi", 5'h04, 32'hffff_ffff, first[63:32]);
        bus(1'b1, 5'h0c, 32'h8000_1234);
        rd("tmo idle", 5'h0c, 32'hffff_ffff, 32'h8000_1234);
        bus(1'b1, 5'h14, 32'hffff_ffff);
        rd("unmapped", 5'h14, 32'hffff_ffff, 32'h0);
        bus(1'b1, 5'h08, 32'hffff_fff3);
        rd("reserved run", 5'h08, 32'h0fff_ffff, 32'h0300_0000);
        due(24);
        bus(1'b1, 5'h08, 32'h1);
        wait (pops == 24);
        bus(1'b1, 5'h0c, 32'h0000_0055);
        rd("tmo busy", 5'h0c, 32'hffff_ffff, 32'h8000_1234);
        do bus(1'b0, 5'h10, 32'h0); while (q[31] !== 1'b1);
        chk("full", q[31:8], 24'h80_0010);
        repeat (20) @(posedge ref_clk);
        chk("fetch held", rd_req.valid, 1'b0);
        bus(1'b1, 5'h08, 32'h2);
        repeat (3) @(posedge ref_clk);
        chk("flushed", desc_out.valid, 1'b0);
        rd("level", 5'h10, 32'hffff_ff00, 32'h0);
        slow <= 1'b0;
        mrr <= 3'h1;
        due(8);
        bus(1'b1, 5'h08, 32'h1);
        wait (pops == lim);
        rd("running", 5'h08, 32'h0f00_000f, 32'h0400_0001);
        finish_test();
    end
endmodule : tb
